// [fmpc_pkg.sv]
// fmpc_pkg: constants for the host-side controller of a parallel nor flash
// assumes a 200 MHz core clock; no software-visible registers
package fmpc_pkg;
  localparam int          CLK_PERIOD_NS   = 5;
  // shortest strobe phase, so pulses never look like device glitches
  localparam int          GLITCH_NS       = 5;
  localparam int          GLITCH_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // each strobe phase length in cycles (setup, strobe low, hold)
  localparam logic [3:0]  PHASE_CYC       = 4'(GLITCH_CYC + 3);
  localparam int          ADDR_W          = 20;
  localparam int          SECT_LSB        = 16;
  localparam int          GRP_LSB         = 17;
  localparam int          A6_POS          = 6;
  // reset command data byte, address is a don't care
  localparam logic [7:0]  RESET_CMD       = 8'hf0;
  // identifier read selectors on address bits 1..0
  localparam logic [1:0]  ID_SEL_MAKER    = 2'h0;
  localparam logic [1:0]  ID_SEL_PART     = 2'h1;
  localparam logic [1:0]  ID_SEL_PROT     = 2'h2;
  localparam logic [7:0]  PROT_FREE_CODE  = 8'h00;
  // operation codes on the command port
  localparam logic [1:0]  OP_READ         = 2'h0;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [1:0]  OP_ID_READ      = 2'h2;
  localparam logic [1:0]  OP_RESET        = 2'h3;
  typedef enum logic [4:0] {
    FMPC_IDLE  = 5'b00001,
    FMPC_SETUP = 5'b00010,
    FMPC_STRB  = 5'b00100,
    FMPC_HOLD  = 5'b01000,
    FMPC_DONE  = 5'b10000
  } fmpc_state_t;
endpackage

// [fmpc_ctrl.sv]
// fmpc_ctrl: host controller driving a parallel nor flash over its pins
// assumes device pins are external; data pins resolved by the testbench
`timescale 1ns/1ps
`default_nettype none
// Contract
// - identifier read drives id line high, a6 low, a1..a0 select code.
// - write only with cs low, we low, oe high; host keeps to it.
// - identifier mode persists until host writes the reset command.
// - after timing-limit error host must write reset command.
module fmpc_ctrl
  import fmpc_pkg::*;
(
  // clock and reset
  input  wire logic                CORE_CLK_I,
  input  wire logic                ARST_N_I,
  // command port
  input  wire logic                REQ_I,
  input  wire logic [1:0]          OP_I,
  input  wire logic [ADDR_W-1:0]   ADDR_I,
  input  wire logic [7:0]          WDATA_I,
  output logic                     BUSY_O,
  output logic                     DONE_O,
  output logic [7:0]               RDATA_O,
  output logic [3:0]               SECTOR_INDEX_O,
  output logic [2:0]               PROTECTION_GROUP_ADDRESS_O,
  output logic                     PROT_O,
  // flash pins
  output logic [ADDR_W-1:0]        FLASH_ADDR_O,
  output logic                     FLASH_CS_N_O,
  output logic                     FLASH_OE_N_O,
  output logic                     FLASH_WE_N_O,
  output logic                     ID_VOLTAGE_ADDRESS_LINE_O,
  input  wire logic [7:0]          DATA_PINS_I,
  output logic [7:0]               DATA_PINS_O,
  output logic                     DATA_PINS_OE_O
);
  import fmpc_pkg::*;

  fmpc_state_t         state_r, state_nxt;
  logic [3:0]          cnt_r;
  logic [1:0]          op_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [7:0]          wdata_r;
  logic [7:0]          d_s1_r, d_s2_r;
  logic [7:0]          rdata_r;
  logic                prot_r;
  logic                done_r;

  // request not yet captured in idle, so the take edge decodes the inputs;
  // otherwise the first setup cycle shows the previous operation's pins
  wire              in_idle   = (state_r == FMPC_IDLE);
  wire [1:0]        op_cur    = in_idle ? OP_I : op_r;
  wire [ADDR_W-1:0] addr_cur  = in_idle ? ADDR_I : addr_r;
  wire [7:0]        wdata_cur = in_idle ? WDATA_I : wdata_r;
  // decoding of the operation
  wire is_write = (op_cur == OP_WRITE) || (op_cur == OP_RESET);
  wire is_id    = (op_cur == OP_ID_READ);
  wire phase_end = (cnt_r == PHASE_CYC - 4'h1);
  // reset command carries fixed data; address is don't care
  wire [7:0] wr_byte = (op_cur == OP_RESET) ? RESET_CMD : wdata_cur;
  // identifier reads force a6 low and keep caller's a1..a0 and top bits
  wire [ADDR_W-1:0] pin_addr = is_id ? (addr_cur & ~(ADDR_W'(1) << A6_POS))
                                     : addr_cur;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FMPC_IDLE:  if (REQ_I) state_nxt = FMPC_SETUP;
      FMPC_SETUP: if (phase_end) state_nxt = FMPC_STRB;
      FMPC_STRB:  if (phase_end) state_nxt = FMPC_HOLD;
      FMPC_HOLD:  if (phase_end) state_nxt = FMPC_DONE;
      FMPC_DONE:  state_nxt = FMPC_IDLE;
      default:    state_nxt = FMPC_IDLE;
    endcase
  end

  // sequencer and request capture
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_r <= FMPC_IDLE;
      cnt_r   <= 4'h0;
      op_r    <= OP_READ;
      addr_r  <= '0;
      wdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_r != state_nxt || state_r == FMPC_IDLE) ? 4'h0 : cnt_r + 4'h1;
      if (state_r == FMPC_IDLE && REQ_I) begin
        op_r    <= OP_I;
        addr_r  <= ADDR_I;
        wdata_r <= OP_I == OP_RESET ? 8'h00 : WDATA_I;
      end
    end
  end

  // pin drive: cs and oe/we framed inside address setup and hold
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FLASH_ADDR_O              <= '0;
      FLASH_CS_N_O              <= 1'b1;
      FLASH_OE_N_O              <= 1'b1;
      FLASH_WE_N_O              <= 1'b1;
      ID_VOLTAGE_ADDRESS_LINE_O <= 1'b0;
      DATA_PINS_O               <= 8'h00;
      DATA_PINS_OE_O            <= 1'b0;
    end else begin
      FLASH_ADDR_O              <= (state_nxt == FMPC_IDLE) ? FLASH_ADDR_O : pin_addr;
      FLASH_CS_N_O              <= !(state_nxt == FMPC_STRB);
      // write: oe stays high while cs and we low; read: we stays high
      FLASH_OE_N_O              <= !(state_nxt == FMPC_STRB && !is_write);
      FLASH_WE_N_O              <= !(state_nxt == FMPC_STRB && is_write);
      ID_VOLTAGE_ADDRESS_LINE_O <= is_id && state_nxt != FMPC_IDLE && state_nxt != FMPC_DONE;
      DATA_PINS_O               <= wr_byte;
      // drive data through setup..hold so it is stable at the rising edge
      DATA_PINS_OE_O            <= is_write && state_nxt != FMPC_IDLE
                                   && state_nxt != FMPC_DONE;
    end
  end

  // read data synchroniser
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      d_s1_r <= 8'h00;
      d_s2_r <= 8'h00;
    end else begin
      d_s1_r <= DATA_PINS_I;
      d_s2_r <= d_s1_r;
    end
  end

  // sample at the end of the hold phase; result and status outputs
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_r <= 8'h00;
      prot_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      done_r <= (state_nxt == FMPC_DONE);
      if (state_r == FMPC_HOLD && phase_end && !is_write) begin
        rdata_r <= d_s2_r;
        // nonzero status byte means the group is protected
        if (is_id && addr_r[1:0] == ID_SEL_PROT)
          prot_r <= (d_s2_r != PROT_FREE_CODE);
      end
    end
  end

  assign RDATA_O = rdata_r;
  assign DONE_O  = done_r;
  assign PROT_O  = prot_r;

  // busy and decoded address fields
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      BUSY_O                     <= 1'b0;
      SECTOR_INDEX_O             <= 4'h0;
      PROTECTION_GROUP_ADDRESS_O <= 3'h0;
    end else begin
      BUSY_O                     <= (state_nxt != FMPC_IDLE);
      SECTOR_INDEX_O             <= addr_r[ADDR_W-1:SECT_LSB];
      PROTECTION_GROUP_ADDRESS_O <= addr_r[ADDR_W-1:GRP_LSB];
    end
  end

  // never write with oe low
  property p_wr_oe;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      !FLASH_WE_N_O |-> (FLASH_OE_N_O && !FLASH_CS_N_O);
  endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write with oe low");

  // strobe low lasts whole phase, longer than glitch limit
  property p_strobe_len;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      $fell(FLASH_CS_N_O) |-> !FLASH_CS_N_O [*4];
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");

  // data driven while oe is low is forbidden
  property p_no_drive_read;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      !FLASH_OE_N_O |-> !DATA_PINS_OE_O;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read) else $error("bus contention");

  // identifier reads keep a6 low
  property p_id_a6;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (ID_VOLTAGE_ADDRESS_LINE_O && !FLASH_CS_N_O) |-> !FLASH_ADDR_O[A6_POS];
  endproperty
  a_id_a6: assert property (p_id_a6) else $error("a6 high in id read");

  // data held one cycle beyond we rising edge
  property p_data_hold;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      $rose(FLASH_WE_N_O) |-> DATA_PINS_OE_O && $stable(DATA_PINS_O);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data hold lost");

  // reset command always carries its fixed data byte
  property p_reset_byte;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (!FLASH_WE_N_O && op_r == OP_RESET) |-> (DATA_PINS_O == RESET_CMD);
  endproperty
  a_reset_byte: assert property (p_reset_byte) else $error("reset byte wrong");

  // identifier read strobes with high voltage applied and oe low
  property p_id_hv;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (!FLASH_CS_N_O && op_r == OP_ID_READ)
      |-> (ID_VOLTAGE_ADDRESS_LINE_O && !FLASH_OE_N_O);
  endproperty
  a_id_hv: assert property (p_id_hv) else $error("id read without high voltage");

  // address holds still for the whole strobe
  property p_addr_steady;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (!FLASH_CS_N_O && !$fell(FLASH_CS_N_O)) |-> $stable(FLASH_ADDR_O);
  endproperty
  a_addr_steady: assert property (p_addr_steady) else $error("address moved in strobe");
endmodule
`default_nettype wire

// [fmpc_flash_model.sv]
// fmpc_flash_model: behavioural parallel nor flash, one byte kept per sector
// assumes the testbench resolves the data pins and feeds them back on pins_i
`timescale 1ns/1ps
`default_nettype none
module fmpc_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'ha5, // arbitrary value
  parameter logic [7:0] STATUS_CODE = 8'h44 // arbitrary status byte
) (
  input  wire logic        clk_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        id_hv_i,
  input  wire logic [7:0]  prot_i,
  input  wire logic        unprot_hv_i,
  input  wire logic        lko_i,
  input  wire logic [15:0] susp_i,
  input  wire logic [7:0]  pins_i,
  output logic      [7:0]  dq_o
);
  logic [7:0]  mem [16];
  logic [19:0] a_lat;
  logic [1:0]  step, hold;
  logic        id_m, pgm;
  realtime     t_fall;
  // write strobe seen by the device
  wire         wr_n = we_n_i | cs_n_i;
  wire  [1:0]  sel  = addr_i[1:0];
  wire  [7:0]  code = sel == 2'h0 ? MAKER_CODE : sel == 2'h1 ? PART_CODE :
                      sel == 2'h2 ? {7'h0, prot_i[addr_i[19:17]]} : 8'h00;
  wire  [7:0]  rd   = ((id_hv_i && !addr_i[6]) || id_m) ? code :
                      susp_i[addr_i[19:16]] ? STATUS_CODE : mem[addr_i[19:16]];
  // erased, unprotected, read-array at power-up; no strobe fall seen yet
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {step, id_m, pgm, hold, dq_o, a_lat} = '0;
    t_fall = -1.0;
  end
  // supply below lockout drops any command in progress
  always @(posedge lko_i) {step, id_m, pgm} = '0;
  // address on the later falling strobe
  always @(negedge wr_n) begin
    a_lat  = addr_i;
    t_fall = $realtime;
  end
  // command decode on the earlier rising strobe, only after a full low pulse with oe high
  always @(posedge wr_n) begin
    if (!lko_i && oe_n_i === 1'b1 && t_fall >= 0.0
        && $realtime - t_fall >= 5.0) begin
      if (pgm) begin
        if (!prot_i[a_lat[19:17]] || unprot_hv_i) mem[a_lat[19:16]] = pins_i;
        pgm = 0;
        step = 0;
      end else if (pins_i == 8'hf0) begin
        step = 0;
        id_m = 0;
      end else if (step == 0 && a_lat[11:0] == 12'h555 && pins_i == 8'haa) step = 1;
      else if (step == 1 && a_lat[11:0] == 12'h2aa && pins_i == 8'h55) step = 2;
      else begin
        pgm = step == 2 && pins_i == 8'ha0;
        id_m = id_m | (step == 2 && pins_i == 8'h90);
        step = 0;
      end
    end
  end
  // drive while selected, hold two cycles, then a changing float pattern
  always @(posedge clk_i)
    if (!cs_n_i && !oe_n_i) begin
      dq_o <= rd;
      hold <= 2'h2;
    end else if (hold != 2'h0) hold <= hold - 2'h1;
    else dq_o <= ~dq_o;
endmodule
`default_nettype wire

// [flash_mode_and_protection_control_tb.sv]
// flash_mode_and_protection_control_tb: self-checking bench for fmpc_ctrl
// assumes fmpc_flash_model on the flash pins and prot driven by the bench
`timescale 1ns/1ps
`default_nettype none
module flash_mode_and_protection_control_tb;
  import fmpc_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
  localparam logic [7:0] PART  = 8'ha5; // arbitrary value
  localparam logic [7:0] STAT  = 8'h44; // arbitrary status byte
  logic clk, arst_n, req, busy, done, prot_o, cs_n, oe_n, we_n, idv, doe;
  logic [1:0] op;
  logic [ADDR_W-1:0] addr, faddr;
  logic [7:0] wdata, prot, rdata, dout, dq, pins;
  logic unprot, lko;
  logic [15:0] susp;
  logic [3:0] sect;
  logic [2:0] grp;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  // host drives the pins when enabled, else the device
  assign pins = doe ? dout : dq;
  fmpc_ctrl dut (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .REQ_I(req), .OP_I(op), .ADDR_I(addr),
    .WDATA_I(wdata), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rdata), .SECTOR_INDEX_O(sect),
    .PROTECTION_GROUP_ADDRESS_O(grp), .PROT_O(prot_o), .FLASH_ADDR_O(faddr),
    .FLASH_CS_N_O(cs_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n),
    .ID_VOLTAGE_ADDRESS_LINE_O(idv), .DATA_PINS_I(pins), .DATA_PINS_O(dout),
    .DATA_PINS_OE_O(doe));
  fmpc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .STATUS_CODE(STAT)) mdl (
    .clk_i(clk), .addr_i(faddr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n), .id_hv_i(idv),
    .prot_i(prot), .unprot_hv_i(unprot), .lko_i(lko), .susp_i(susp),
    .pins_i(pins), .dq_o(dq));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // hang guard and strobe watch
  always @(negedge clk) begin
    cycles++;
    if (arst_n && !we_n && !oe_n) begin
      num_errors++;
      $display("BAD strobes exp oe high seen low");
    end
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(logic [1:0] o, logic [19:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {req, op, addr, wdata} <= {1'b1, o, a, d};
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    chk("done", {7'h0, done}, 8'h01);
    chk("latency", 8'(n), 8'(3 * PHASE_CYC + 1));
    chk("busy", {7'h0, busy}, 8'h01);
    @(negedge clk);
    chk("done_end", {7'h0, done}, 8'h00);
    chk("idle", {7'h0, busy}, 8'h00);
  endtask
  task automatic wr(logic [19:0] a, logic [7:0] d);
    xfer(OP_WRITE, a, d);
  endtask
  task automatic rd(logic [1:0] o, logic [19:0] a, logic [7:0] e, string nm);
    xfer(o, a, 8'h00);
    chk(nm, rdata, e);
  endtask
  task automatic unlock;
    wr(20'h0_0555, 8'haa);
    wr(20'h0_02aa, 8'h55);
  endtask
  task automatic t_erased;
    rd(OP_READ, 20'h7_0000, 8'hff, "erased");
    rd(OP_ID_READ, 20'hf_0002, 8'h00, "prot_free");
    chk("prot_o_free", {7'h0, prot_o}, 8'h00);
  endtask
  task automatic t_program;
    unlock();
    wr(20'h0_0555, 8'ha0);
    wr(20'h3_0123, 8'h3c);
    rd(OP_READ, 20'h3_0123, 8'h3c, "prog");
    chk("sector", {4'h0, sect}, 8'h03);
    chk("group", {5'h0, grp}, 8'h01);
  endtask
  task automatic t_protect;
    prot <= 8'h04;
    unlock();
    wr(20'h0_0555, 8'ha0);
    wr(20'h5_0000, 8'h11);
    rd(OP_READ, 20'h5_0000, 8'hff, "refused");
    unprot <= 1'b1;
    unlock();
    wr(20'h0_0555, 8'ha0);
    wr(20'h5_0000, 8'h11);
    unprot <= 1'b0;
    rd(OP_READ, 20'h5_0000, 8'h11, "temp_unprot");
    rd(OP_ID_READ, 20'h4_0002, 8'h01, "prot_set");
    chk("prot_o", {7'h0, prot_o}, 8'h01);
    rd(OP_ID_READ, 20'h0_0040, MAKER, "maker");
    rd(OP_ID_READ, 20'h0_0001, PART, "part");
    prot <= 8'h00;
  endtask
  task automatic t_idcmd;
    unlock();
    wr(20'h0_0555, 8'h90);
    rd(OP_READ, 20'h2_0001, PART, "id_cmd");
    rd(OP_READ, 20'h3_0120, MAKER, "id_stays");
    xfer(OP_RESET, 20'hf_ffff, 8'h00);
    rd(OP_READ, 20'h3_0123, 8'h3c, "after_reset");
  endtask
  task automatic t_lockout;
    lko <= 1'b1;
    unlock();
    wr(20'h0_0555, 8'ha0);
    wr(20'h6_0000, 8'h22);
    lko <= 1'b0;
    rd(OP_READ, 20'h6_0000, 8'hff, "lockout");
  endtask
  task automatic t_suspend;
    susp <= 16'h0080;
    rd(OP_READ, 20'h7_0010, STAT, "susp_status");
    rd(OP_READ, 20'h3_0123, 8'h3c, "susp_array");
    susp <= 16'h0000;
  endtask
  task automatic t_reset;
    @(posedge clk);
    {req, op, addr} <= {1'b1, OP_READ, 20'h3_0123};
    @(posedge clk);
    req <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk("rst_busy", {7'h0, busy}, 8'h00);
    chk("rst_pins", {5'h0, cs_n, oe_n, we_n}, 8'h07);
    chk("rst_idv", {7'h0, idv}, 8'h00);
    chk("rst_rdata", rdata, 8'h00);
    chk("rst_prot", {7'h0, prot_o}, 8'h00);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(OP_READ, 20'h3_0123, 8'h3c, "after_rst");
  endtask
  task automatic t_abort;
    unlock();
    xfer(OP_RESET, 20'h0_0555, 8'h00);
    wr(20'h0_0555, 8'ha0);
    wr(20'h0_0010, 8'h11);
    rd(OP_READ, 20'h0_0010, 8'hff, "abort");
  endtask
  task automatic summarize;
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {arst_n, req, op, addr, wdata, prot, unprot, lko, susp} = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_erased();
    t_program();
    t_protect();
    t_idcmd();
    t_lockout();
    t_suspend();
    t_reset();
    t_abort();
    summarize();
  end
endmodule
`default_nettype wire
